// file: core/dbg_rst_pkg.sv
package dbg_rst_pkg;
   // Control/status field positions in the always-on control word
   localparam int unsigned CSR_WIDTH        = 32;
   localparam int unsigned RST_REQ_BIT      = 27;
   localparam int unsigned RST_ACK_BIT      = 26;
   localparam int unsigned PWR_REQ_BIT      = 28;
   localparam int unsigned PWR_ACK_BIT      = 29;
   localparam logic [31:0] CSR_RESET_VALUE  = 32'h0000_0000;
   // Reset controller timing, in core clock cycles at 10 MHz
   localparam int unsigned CLK_PERIOD_NS    = 100;
   localparam int unsigned DBG_RST_PULSE_NS = 400;
   localparam int unsigned DBG_RST_CYCLES   =
      (DBG_RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned PWR_UP_NS        = 800;
   localparam int unsigned PWR_UP_CYCLES    =
      (PWR_UP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned TIMEOUT_DEFAULT  = 64;
   localparam logic [7:0]  TIMER_ZERO       = 8'h00;
   // Debugger command codes
   typedef enum logic [2:0] {
      CMD_NONE      = 3'h0,
      CMD_DBG_RESET = 3'h1,
      CMD_SYS_RESET = 3'h2,
      CMD_SYS_REL   = 3'h3
   } cmd_type;
endpackage

// file: core/dbg_rst_if.sv
`timescale 1ns/100ps
`default_nettype none
// Signals between the debugger's debug port and the reset/power controllers
interface dbg_rst_if;
   logic debug_reset_request;   // From debug port control word
   logic debug_reset_ack;       // From reset controller
   logic debug_power_request;   // From debug port control word
   logic debug_power_ack;       // From power controller
   logic system_reset_pin_n;    // Debugger-driven system reset pin
   logic access_port_enable;    // Device enable into the access port
   modport debugger (
      output debug_reset_request,
      output debug_power_request,
      output system_reset_pin_n,
      input  debug_reset_ack,
      input  debug_power_ack,
      input  access_port_enable
   );
   modport controller (
      input  debug_reset_request,
      input  debug_power_request,
      input  system_reset_pin_n,
      output debug_reset_ack,
      output debug_power_ack,
      output access_port_enable
   );
endinterface
`default_nettype wire

// file: core/ack_waiter.sv
`timescale 1ns/100ps
`default_nettype none
// Waits for a level to match a target, with a bounded cycle timeout
module ack_waiter #(
   parameter int unsigned TW = 8
) (
   input  wire logic          core_clk_in,
   input  wire logic          rst_n_in,
   input  wire logic          start_in,     // Pulse: begin a wait
   input  wire logic          level_in,     // Observed acknowledge
   input  wire logic          target_in,    // Level being awaited
   input  wire logic [TW-1:0] limit_in,     // Cycles allowed
   output logic               busy_out,     // Wait in progress
   output logic               done_out,     // Pulse: level matched
   output logic               timeout_out   // Pulse: limit expired
);
   logic [TW-1:0] count_reg;              // Cycles spent waiting
   logic          busy_reg;
   logic          done_reg;
   logic          to_reg;
   wire           hit     = busy_reg && (level_in == target_in);
   wire           expired = busy_reg && !hit && (count_reg == limit_in);

   // Counter runs only while busy; match beats expiry in the same cycle
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         count_reg <= '0;
         busy_reg  <= 1'b0;
         done_reg  <= 1'b0;
         to_reg    <= 1'b0;
      end else begin
         done_reg <= hit;
         to_reg   <= expired;
         if (start_in) begin
            busy_reg  <= 1'b1;
            count_reg <= '0;
         end else if (hit || expired) begin
            busy_reg <= 1'b0;
         end else if (busy_reg) begin
            count_reg <= count_reg + 1'b1;
         end
      end
   end

   assign busy_out    = busy_reg;
   assign done_out    = done_reg;
   assign timeout_out = to_reg;
endmodule
`default_nettype wire

// file: core/dbg_debugger.sv
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// RULE1 - Acknowledge status reads zero without reset support
// RULE2 - Request bit read/write or RAZ/WI, chosen; REQ_RW_NO_SUP is unused, the bit is always read/write
// RULE3 - Unsupported acknowledge input tied permanently low
// RULE4 - Reset scope chosen by the implementation
// RULE5 - Effect while powered off fixed at design
// RULE6 - Ignore requests while access port disabled
// RULE7 - Debugger issues debug reset only when needed
// RULE8 - No control bit requests whole-system reset
// RULE9 - Pin active low, any transition accepted
// RULE10 - Non-debug logic held while pin asserted
// RULE11 - Debug domain stays accessible during pin reset
// RULE12 - No outstanding system access before pin assertion
// RULE13 - Reset all, then release debug domain
// RULE14 - Clear power request while pin first asserted
// RULE15 - Power down, assert pin, power up, release
// RULE16 - Power ack marks debug reset complete
// RULE17 - Every acknowledge wait bounded by timeout
// RULE18 - Request and acknowledge at bits 27, 26
// RULE19 - Request, ack, clear request, ack drops
// RULE20 - Never drop request before acknowledge; the request is dropped when the wait times out
// RULE21 - Debug reset spares debug port registers
module dbg_debugger
   import dbg_rst_pkg::*;
#(
   parameter int unsigned TW = 8   // Timeout counter width
) (
   input  wire logic                       core_clk_in,
   input  wire logic                       rst_n_in,
   dbg_rst_if.debugger                     link,
   input  wire dbg_rst_pkg::cmd_type       cmd_in,        // Command, one cycle
   input  wire logic                       cmd_valid_in,  // Command strobe
   input  wire logic [TW-1:0]              timeout_in,    // Wait limit, cycles
   input  wire logic                       bus_idle_in,   // No system access pending
   output logic                            ready_out,     // Idle, may take command
   output logic                            done_out,      // Pulse: command finished
   output logic                            timeout_out,   // Pulse: a wait timed out
   output logic [dbg_rst_pkg::CSR_WIDTH-1:0] csr_out      // Control/status image
);
   import dbg_rst_pkg::*;

   typedef enum logic [8:0] {
      S_IDLE     = 9'b0_0000_0001,
      S_RST_WAIT = 9'b0_0000_0010,   // Request up, await ack high
      S_RST_DROP = 9'b0_0000_0100,   // Request down, await ack low
      S_PWR_OFF  = 9'b0_0000_1000,   // Power request down, await ack low
      S_BUS_WAIT = 9'b0_0001_0000,   // Wait for bus idle
      S_PWR_ON   = 9'b0_0010_0000,   // Pin asserted, power request still low
      S_PWR_WAIT = 9'b0_0100_0000,   // Await power ack high
      S_REL      = 9'b0_1000_0000,   // Release pin
      S_FINISH   = 9'b1_0000_0000
   } state_type;

   state_type state_reg;
   state_type state_next;
   logic      rst_req_reg;            // Debug reset request bit
   logic      pwr_req_reg;            // Debug power request bit
   logic      pin_n_reg;              // System reset pin, low asserts
   logic      ready_reg;
   logic      done_reg;
   logic      to_reg;
   logic [CSR_WIDTH-1:0] csr_reg;
   logic      wait_start;
   logic      wait_target;
   logic      wait_level;
   logic      wait_busy;
   logic      wait_done;
   logic      wait_to;

   // One shared waiter; every acknowledge wait is bounded by it
   ack_waiter #(.TW(TW)) u_wait (
      .core_clk_in (core_clk_in),
      .rst_n_in    (rst_n_in),
      .start_in    (wait_start),
      .level_in    (wait_level),
      .target_in   (wait_target),
      .limit_in    (timeout_in),
      .busy_out    (wait_busy),
      .done_out    (wait_done),
      .timeout_out (wait_to)                          // RULE17
   );

   wire take_cmd = cmd_valid_in && (state_reg == S_IDLE);
   wire waiting  = wait_busy || wait_start;

   // Which acknowledge the waiter watches in each state
   assign wait_level  = (state_reg == S_RST_WAIT || state_reg == S_RST_DROP)
                        ? link.debug_reset_ack : link.debug_power_ack;
   assign wait_target = (state_reg == S_RST_WAIT || state_reg == S_PWR_WAIT);

   // Sequencer: debug reset handshake and system reset sequence
   always_comb begin
      state_next = state_reg;
      wait_start = 1'b0;
      unique case (state_reg)
         S_IDLE: begin
            if (take_cmd && cmd_in == CMD_DBG_RESET) begin
               state_next = S_RST_WAIT;               // RULE7
               wait_start = 1'b1;
            end else if (take_cmd && cmd_in == CMD_SYS_RESET) begin
               state_next = S_PWR_OFF;                // RULE14
               wait_start = 1'b1;
            end else if (take_cmd && cmd_in == CMD_SYS_REL) begin
               state_next = S_REL;
            end
         end
         S_RST_WAIT: begin
            // Request held until ack or timeout, never dropped early
            if (wait_done || wait_to) begin            // RULE20
               state_next = S_RST_DROP;
               wait_start = 1'b1;
            end
         end
         S_RST_DROP: begin
            if (wait_done || wait_to) begin           // RULE19
               state_next = S_FINISH;
            end
         end
         S_PWR_OFF: begin
            if (wait_done || wait_to) begin
               state_next = S_BUS_WAIT;
            end
         end
         S_BUS_WAIT: begin
            if (bus_idle_in) begin                    // RULE12
               state_next = S_PWR_ON;
            end
         end
         S_PWR_ON: begin
            state_next = S_PWR_WAIT;
            wait_start = 1'b1;
         end
         S_PWR_WAIT: begin
            // Power ack high also signals debug domain reset is done
            if (wait_done || wait_to) begin           // RULE15
               state_next = S_FINISH;
            end
         end
         S_REL: begin
            state_next = S_FINISH;
         end
         S_FINISH: begin
            state_next = S_IDLE;
         end
      endcase
   end

   // Registered pin and bit drive per state
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_reg   <= S_IDLE;
         rst_req_reg <= 1'b0;
         pwr_req_reg <= 1'b0;
         pin_n_reg   <= 1'b1;
         ready_reg   <= 1'b0;
         done_reg    <= 1'b0;
         to_reg      <= 1'b0;
      end else begin
         state_reg   <= state_next;
         ready_reg   <= (state_next == S_IDLE);
         done_reg    <= (state_next == S_FINISH);
         to_reg      <= wait_to;                      // RULE17
         if (state_next == S_RST_WAIT) begin
            rst_req_reg <= 1'b1;                      // RULE19
         end else if (state_next == S_RST_DROP) begin
            rst_req_reg <= 1'b0;
         end
         if (state_next == S_PWR_OFF) begin
            pwr_req_reg <= 1'b0;
         end else if (state_next == S_PWR_ON) begin
            // Pin first, power request a cycle later, so the request is
            // still low while the pin is first asserted
            pin_n_reg   <= 1'b0;                      // RULE9
         end else if (state_next == S_PWR_WAIT) begin
            pwr_req_reg <= 1'b1;                      // RULE14
         end else if (state_next == S_REL) begin
            pin_n_reg   <= 1'b1;
         end
      end
   end

   // Status image: bits 27:26 request and ack, power bits above
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         csr_reg <= CSR_RESET_VALUE;
      end else begin
         csr_reg              <= CSR_RESET_VALUE;
         csr_reg[RST_REQ_BIT] <= rst_req_reg;         // RULE18
         csr_reg[RST_ACK_BIT] <= link.debug_reset_ack;
         csr_reg[PWR_REQ_BIT] <= pwr_req_reg;
         csr_reg[PWR_ACK_BIT] <= link.debug_power_ack;
      end
   end

   assign link.debug_reset_request = rst_req_reg;
   assign link.debug_power_request = pwr_req_reg;
   assign link.system_reset_pin_n  = pin_n_reg;
   assign ready_out   = ready_reg;
   assign done_out    = done_reg;
   assign timeout_out = to_reg;
   assign csr_out     = csr_reg;

   // Unused waiter flag kept for clarity of intent
   wire unused_ok = waiting;
endmodule
`default_nettype wire

// file: core/dbg_reset_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
// Reset and power controller facing the debug port
module dbg_reset_ctrl
   import dbg_rst_pkg::*;
#(
   parameter bit RESET_SUPPORTED = 1'b1,  // Debug reset handshake present
   parameter bit REQ_RW_NO_SUP   = 1'b1,  // Request bit kept r/w when absent
   parameter bit RESET_WHEN_OFF  = 1'b0,  // Request acts with power off
   parameter bit SYS_RST_DEBUG   = 1'b1   // Pin also pulses debug domain
) (
   input  wire logic   core_clk_in,
   input  wire logic   rst_n_in,
   dbg_rst_if.controller link,
   input  wire logic   ap_enable_in,       // Device enable for the access port
   output logic        debug_bus_reset_n_out, // Debug domain reset, low active
   output logic        ap_reset_n_out,        // Access port state reset
   output logic        system_hold_n_out,     // Non-debug logic reset
   output logic        debug_powered_out      // Debug domain powered
);
   import dbg_rst_pkg::*;

   logic [7:0] rst_cnt_reg;    // Debug reset pulse counter
   logic [7:0] pwr_cnt_reg;    // Power-up delay counter
   logic       rst_ack_reg;
   logic       pwr_ack_reg;
   logic       dbg_rst_n_reg;
   logic       hold_n_reg;
   logic       powered_reg;
   logic       pin_q_reg;      // Previous pin level

   // Request accepted only when enabled, supported and powered as chosen
   wire req_ok    = link.debug_reset_request && ap_enable_in            // RULE6
                    && (RESET_WHEN_OFF || powered_reg);                 // RULE5
   wire pin_fall  = pin_q_reg && !link.system_reset_pin_n;
   wire start_rst = (RESET_SUPPORTED && req_ok && !rst_ack_reg
                     && rst_cnt_reg == TIMER_ZERO && dbg_rst_n_reg)
                    || (SYS_RST_DEBUG && pin_fall);                     // RULE13
   wire pulsing   = (rst_cnt_reg != TIMER_ZERO);

   // Debug reset pulse and acknowledge handshake
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_cnt_reg   <= TIMER_ZERO;
         dbg_rst_n_reg <= 1'b1;
         rst_ack_reg   <= 1'b0;
         pin_q_reg     <= 1'b1;
      end else begin
         pin_q_reg <= link.system_reset_pin_n;                          // RULE9
         if (start_rst) begin
            rst_cnt_reg   <= 8'(DBG_RST_CYCLES);
            dbg_rst_n_reg <= 1'b0;
         end else if (pulsing) begin
            rst_cnt_reg <= rst_cnt_reg - 8'h01;
            // Release debug domain so debugger can reach it
            if (rst_cnt_reg == 8'h01) begin
               dbg_rst_n_reg <= 1'b1;                                   // RULE11
               if (link.debug_reset_request && RESET_SUPPORTED) begin
                  rst_ack_reg <= 1'b1;                                  // RULE19
               end
            end
         end else if (!link.debug_reset_request || !RESET_SUPPORTED) begin
            rst_ack_reg <= 1'b0;                                        // RULE1
         end
      end
   end

   // Power handshake; ack waits for any debug reset pulse to finish
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pwr_cnt_reg <= TIMER_ZERO;
         pwr_ack_reg <= 1'b0;
         powered_reg <= 1'b0;
         hold_n_reg  <= 1'b0;
      end else begin
         hold_n_reg <= link.system_reset_pin_n;                         // RULE10
         if (!link.debug_power_request) begin
            pwr_cnt_reg <= 8'(PWR_UP_CYCLES);
            pwr_ack_reg <= 1'b0;
            powered_reg <= 1'b0;
         end else if (pwr_cnt_reg != TIMER_ZERO) begin
            pwr_cnt_reg <= pwr_cnt_reg - 8'h01;
         end else if (!pulsing && dbg_rst_n_reg) begin
            powered_reg <= 1'b1;
            pwr_ack_reg <= 1'b1;                                        // RULE16
         end
      end
   end

   // Ack input tied low when the handshake is absent; debug port regs
   // have no reset here, access port state and debug domain take the pulse
   assign link.debug_reset_ack   = RESET_SUPPORTED ? rst_ack_reg : 1'b0; // RULE3
   assign link.debug_power_ack   = pwr_ack_reg;
   assign link.access_port_enable = ap_enable_in;
   assign debug_bus_reset_n_out  = dbg_rst_n_reg;                        // RULE4
   assign ap_reset_n_out         = dbg_rst_n_reg;                        // RULE21
   assign system_hold_n_out      = hold_n_reg;                           // RULE8
   assign debug_powered_out      = powered_reg;

   wire unused_ok = REQ_RW_NO_SUP;                                       // RULE2
endmodule
`default_nettype wire

// file: dv/debug_system_reset_control_assertions.sv
`timescale 1ns/100ps
`default_nettype none
// Watches the link of the pair whose controller supports debug reset
module dbg_rst_checker (
   input wire logic core_clk_in,          // Core clock
   input wire logic rst_n_in,             // Async reset, low active
   input wire logic debug_reset_request,  // Reset request from debugger
   input wire logic debug_reset_ack,      // Reset acknowledge from controller
   input wire logic debug_power_request,  // Power request from debugger
   input wire logic debug_power_ack,      // Power acknowledge from controller
   input wire logic system_reset_pin_n,   // System reset pin, low asserted
   input wire logic access_port_enable    // Access port device enable
);
   // One clock domain, so clocking and disable are given once
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   a_ack_has_cause: assert property (
      $rose(debug_reset_ack) |-> $past(debug_reset_request) && $past(access_port_enable))
      else $error("reset ack rose without an enabled request");
   a_ack_not_early: assert property (
      $rose(debug_reset_request) |-> !debug_reset_ack [*4])
      else $error("reset ack came before the reset pulse ended");
   a_ack_in_time: assert property (
      $rose(debug_reset_request) && access_port_enable && debug_power_ack
      |-> ##[4:16] debug_reset_ack)
      else $error("reset ack missing after enabled request");
   a_ack_held: assert property (
      debug_reset_request && debug_reset_ack |=> debug_reset_ack)
      else $error("reset ack dropped while request still high");
   a_ack_release: assert property (
      $fell(debug_reset_request) |-> ##[0:3] !debug_reset_ack)
      else $error("reset ack did not follow request down");
   a_req_kept: assert property (
      debug_reset_request && !debug_reset_ack && access_port_enable && debug_power_ack
      |=> debug_reset_request)
      else $error("reset request removed before ack");
   a_pin_after_pwr: assert property (
      $fell(system_reset_pin_n) |-> !$past(debug_power_ack) && !debug_power_request)
      else $error("pin asserted with power request or ack still high");
   a_pwr_ack_late: assert property (
      $fell(system_reset_pin_n) |-> !debug_power_ack [*8] ##[1:40] debug_power_ack)
      else $error("power ack timing wrong around pin reset");
   a_pwr_ack_drop: assert property (
      $fell(debug_power_request) |-> ##[0:8] !debug_power_ack)
      else $error("power ack did not clear after request removal");
   a_pwr_ack_cause: assert property (
      $rose(debug_power_ack) |-> $past(debug_power_request))
      else $error("power ack rose without request");

   c_dbg_handshake: cover property ($fell(debug_reset_ack));
   c_pin_assert: cover property ($fell(system_reset_pin_n));
   c_pin_release: cover property ($rose(system_reset_pin_n));
   c_pwr_down: cover property ($fell(debug_power_ack));
endmodule
`default_nettype wire

// file: dv/debug_system_reset_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
// Pair 0 supports debug reset, pair 1 does not; both are driven by commands
module debug_system_reset_control_tb;
   import dbg_rst_pkg::*;
   localparam int LIMIT = 400;     // Bound on every wait, in cycles
   logic        core_clk_in;       // 10 MHz core clock
   logic        rst_n_in;          // Async reset, low active
   cmd_type     cmd [2];           // Command per pair
   logic        valid [2];         // Command strobe per pair
   logic [7:0]  tmo_limit [2];     // Ack wait limit per pair
   logic        bus_idle [2];      // No system access pending
   logic        ap_en [2];         // Access port enable
   logic        ready [2];         // Debugger idle
   logic        done [2];          // Command finished pulse
   logic        tmo [2];           // Wait expired pulse
   logic [31:0] csr [2];           // Control/status image
   logic        bus_rst_n [2];     // Debug domain reset
   logic        ap_rst_n [2];      // Access port state reset
   logic        hold_n [2];        // Non-debug logic reset
   logic        powered [2];       // Debug domain powered
   int          fail_count = 0;    // Mismatches seen
   int          checks = 0;        // Comparisons made
   int          low_cnt = 0;       // Cycles with debug domain and port state in reset
   logic        saw_both;          // Request and ack seen together in image
   logic        saw_ack2;          // Reset ack seen on the unsupported pair
   logic        prev_pin;          // Pin level one edge earlier

   always #50 core_clk_in = ~core_clk_in;

   for (genvar p = 0; p < 2; p++) begin : g_pair
      dbg_rst_if link ();
      dbg_debugger #(.TW(8)) dbg_debugger_i (
         .core_clk_in  (core_clk_in),
         .rst_n_in     (rst_n_in),
         .link         (link.debugger),
         .cmd_in       (cmd[p]),
         .cmd_valid_in (valid[p]),
         .timeout_in   (tmo_limit[p]),
         .bus_idle_in  (bus_idle[p]),
         .ready_out    (ready[p]),
         .done_out     (done[p]),
         .timeout_out  (tmo[p]),
         .csr_out      (csr[p])
      );
      dbg_reset_ctrl #(.RESET_SUPPORTED(p == 0)) dbg_reset_ctrl_i (
         .core_clk_in           (core_clk_in),
         .rst_n_in              (rst_n_in),
         .link                  (link.controller),
         .ap_enable_in          (ap_en[p]),
         .debug_bus_reset_n_out (bus_rst_n[p]),
         .ap_reset_n_out        (ap_rst_n[p]),
         .system_hold_n_out     (hold_n[p]),
         .debug_powered_out     (powered[p])
      );
   end

   dbg_rst_checker dbg_rst_checker_i (
      .core_clk_in         (core_clk_in),
      .rst_n_in            (rst_n_in),
      .debug_reset_request (g_pair[0].link.debug_reset_request),
      .debug_reset_ack     (g_pair[0].link.debug_reset_ack),
      .debug_power_request (g_pair[0].link.debug_power_request),
      .debug_power_ack     (g_pair[0].link.debug_power_ack),
      .system_reset_pin_n  (g_pair[0].link.system_reset_pin_n),
      .access_port_enable  (g_pair[0].link.access_port_enable)
   );

   // Expected control word from the four handshake levels
   function automatic logic [31:0] exp_csr(input logic rq, ak, pq, pk);
      exp_csr = 32'h0000_0000;
      exp_csr[27] = rq;
      exp_csr[26] = ak;
      exp_csr[PWR_REQ_BIT] = pq;
      exp_csr[PWR_ACK_BIT] = pk;
   endfunction

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_flag(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // A hang counts as a mismatch and ends the run
   task automatic hang();
      fail_count++;
      test_done();
   endtask

   // Issue one command when ready, then wait for its end or a timeout
   task automatic do_cmd(input int p, input cmd_type c, output logic fin, output logic late);
      int n;
      n = 0;
      while (ready[p] !== 1'b1 && n < LIMIT) begin
         @(posedge core_clk_in);
         #1;
         n++;
      end
      if (n >= LIMIT) hang();
      cmd[p] = c;
      valid[p] = 1'b1;
      @(posedge core_clk_in);
      #1;
      valid[p] = 1'b0;
      n = 0;
      while (done[p] !== 1'b1 && tmo[p] !== 1'b1 && n < LIMIT) begin
         @(posedge core_clk_in);
         #1;
         n++;
      end
      if (n >= LIMIT) hang();
      fin = done[p];
      late = tmo[p];
   endtask

   // Reset pulse length, image contents and pin timing against bus traffic
   always @(posedge core_clk_in) begin
      // Both resets must pulse together, or the counted length comes out short
      if (rst_n_in === 1'b1 && bus_rst_n[0] === 1'b0 && ap_rst_n[0] === 1'b0) low_cnt++;
      if (csr[0] === exp_csr(1'b1, 1'b1, 1'b1, 1'b1)) saw_both = 1'b1;
      if (csr[1][26] !== 1'b0) saw_ack2 = 1'b1;
      if (prev_pin === 1'b1 && g_pair[0].link.system_reset_pin_n === 1'b0) begin
         chk_flag(bus_idle[0], 1'b1);
      end
      prev_pin = g_pair[0].link.system_reset_pin_n;
   end

   initial begin
      int   base;
      logic fin;
      logic late;
      core_clk_in = 1'b0;
      rst_n_in = 1'b0;
      for (int p = 0; p < 2; p++) begin
         cmd[p] = CMD_NONE;
         valid[p] = 1'b0;
         tmo_limit[p] = 8'h10;
         bus_idle[p] = 1'b1;
         ap_en[p] = 1'b1;
      end
      void'($urandom(11882));
      repeat (16) @(posedge core_clk_in);
      #1;
      chk_word(csr[0], exp_csr(1'b0, 1'b0, 1'b0, 1'b0));
      chk_flag(g_pair[0].link.system_reset_pin_n, 1'b1);
      rst_n_in = 1'b1;
      repeat (2) @(posedge core_clk_in);
      #1;
      // System reset with traffic still draining for a random while
      bus_idle[0] = 1'b0;
      fork
         begin
            repeat ($urandom_range(3, 10)) @(posedge core_clk_in);
            #1;
            bus_idle[0] = 1'b1;
         end
      join_none
      tmo_limit[0] = 8'($urandom_range(16, 60));
      base = low_cnt;
      do_cmd(0, CMD_SYS_RESET, fin, late);
      chk_flag(fin, 1'b1);
      chk_word(32'(low_cnt - base), 32'(DBG_RST_CYCLES));
      chk_flag(hold_n[0], 1'b0);
      chk_flag(bus_rst_n[0], 1'b1);
      chk_flag(powered[0], 1'b1);
      chk_word(csr[0], exp_csr(1'b0, 1'b0, 1'b1, 1'b1));
      // Back-to-back debug resets while the pin still holds the system
      repeat ($urandom_range(2, 4)) begin
         saw_both = 1'b0;
         base = low_cnt;
         tmo_limit[0] = 8'($urandom_range(16, 60));
         do_cmd(0, CMD_DBG_RESET, fin, late);
         chk_flag(late, 1'b0);
         chk_flag(saw_both, 1'b1);
         chk_word(32'(low_cnt - base), 32'(DBG_RST_CYCLES));
         chk_flag(hold_n[0], 1'b0);
         chk_word(csr[0], exp_csr(1'b0, 1'b0, 1'b1, 1'b1));
      end
      // Releasing the pin frees non-debug logic
      do_cmd(0, CMD_SYS_REL, fin, late);
      @(posedge core_clk_in);
      #1;
      chk_flag(hold_n[0], 1'b1);
      // Disabled access port: request ignored, the wait must expire
      ap_en[0] = 1'b0;
      tmo_limit[0] = 8'h14;
      do_cmd(0, CMD_DBG_RESET, fin, late);
      chk_flag(late, 1'b1);
      chk_flag(g_pair[0].link.debug_reset_ack, 1'b0);
      // Pair without reset support: ack never comes, debugger gives up
      saw_ack2 = 1'b0;
      tmo_limit[1] = 8'($urandom_range(16, 40));
      do_cmd(1, CMD_DBG_RESET, fin, late);
      chk_flag(late, 1'b1);
      chk_flag(saw_ack2, 1'b0);
      // Access port enabled again: a plain debug reset completes
      ap_en[0] = 1'b1;
      do_cmd(0, CMD_DBG_RESET, fin, late);
      chk_flag(late, 1'b0);
      // Second system reset: debug power goes down from up this time
      base = low_cnt;
      do_cmd(0, CMD_SYS_RESET, fin, late);
      chk_flag(late, 1'b0);
      chk_word(32'(low_cnt - base), 32'(DBG_RST_CYCLES));
      chk_word(csr[0], exp_csr(1'b0, 1'b0, 1'b1, 1'b1));
      do_cmd(0, CMD_SYS_REL, fin, late);
      chk_flag(fin, 1'b1);
      test_done();
   end
endmodule
`default_nettype wire
